//--- port_pin_function_mux_params.svh
/*
 Timing-free constants for the port pin function multiplexer: widths,
 reset values and bit positions of shared pins.
 Assumes inclusion by bare name from the package and the module.
*/
`ifndef PORT_PIN_FUNCTION_MUX_PARAMS_SVH
`define PORT_PIN_FUNCTION_MUX_PARAMS_SVH
`define P0_WIDTH 5
`define P1_WIDTH 4
`define P8_WIDTH 8
`define SEG_PORTS 5
`define SEG_COUNT 40
`define DIR_RESET 8'h00
`define P0_IRQ0_BIT 0
`define P0_IRQ1_BIT 1
`define P0_IRQ2_BIT 2
`define P0_T8A_BIT 3
`define P0_T8B_BIT 4
`define P4_AMP_BIT 6
`define P4_SND_BIT 7
`define P12_CLKOUT_BIT 0
`define P12_T16_BIT 1
`define P12_CAP_BIT 2
`define P12_RXD_BIT 3
`define P12_TXD_BIT 4
`define P12_SCK_BIT 5
`define P12_SO_BIT 6
`define P12_SI_BIT 7
`endif

//--- port_pin_function_mux_pkg.sv
/*
 Types for the port pin function multiplexer.
 Assumes the params header is on the include path.
*/
`include "port_pin_function_mux_params.svh"
package port_pin_function_mux_pkg;
   typedef enum logic [1:0] {edge_none, edge_rise, edge_fall, edge_both} edge_sel_t;
   typedef struct packed {
      logic [2:0] irq_meta;
      logic [2:0] irq_sync;
      logic [2:0] irq_last;
      logic [2:0] irq_pulse;
      logic [2:0] irq_warm;
      logic [3:0] t_meta;
      logic [3:0] t_sync;
      logic [2:0] r_meta;
      logic [2:0] r_sync;
      logic bus_tx;
      logic [56:0] pin_meta;
      logic [56:0] pin_sync;
      logic [2:0] bus_meta;
      logic [2:0] bus_sync;
   } state_t;
endpackage

//--- port_pin_function_mux.sv
/*
 Pin multiplexer for the general ports: direction, alternate functions,
 segment selection, interrupt edge detection, input synchronisers.
 Assumes peripherals and port latches run on clk; pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_function_mux_params.svh"
module port_pin_function_mux (
   input wire logic clk, // system clock 125 MHz
   input wire logic reset_n, // async reset, active low
   input wire logic [4:0] p0_in, // port 0 pin levels
   output logic [4:0] p0_out, // port 0 pin drive
   output logic [4:0] p0_oe, // port 0 output enable
   input wire logic [4:0] p0_latch, // port 0 output latch
   input wire logic [4:0] p0_dir_out, // port 0 direction, 1 = output
   input wire logic [3:0] p1_in, // port 1 input pins
   output logic [3:0] analog_in_lines, // to the converter
   input wire logic [7:0] p4_in, // port 4 pin levels
   output logic [7:0] p4_out, // port 4 pin drive
   output logic [7:0] p4_oe, // port 4 output enable
   input wire logic [7:0] p4_latch, // port 4 output latch
   input wire logic [7:0] p4_dir_out, // port 4 direction
   input wire logic [39:0] segp_in, // ports 8..12 pins, port 8 low
   output logic [39:0] segp_out, // ports 8..12 drive
   output logic [39:0] segp_oe, // ports 8..12 enable
   input wire logic [39:0] segp_latch, // ports 8..12 latches
   input wire logic [39:0] segp_dir_out, // ports 8..12 direction
   input wire logic [39:0] seg_func, // port function, 1 = segment
   input wire logic [39:0] lcd_segment_lines, // segment waveform, index = segment
   output logic [4:0] p0_rd, // port 0 read data
   output logic [3:0] p1_rd, // port 1 read data
   output logic [7:0] p4_rd, // port 4 read data
   output logic [39:0] segp_rd, // ports 8..12 read data
   input wire logic [1:0] irq_edge_0, // edge select, ext irq 0
   input wire logic [1:0] irq_edge_1, // edge select, ext irq 1
   input wire logic [1:0] irq_edge_2, // edge select, ext irq 2
   output logic ext_irq_in_0, // edge detected pulse
   output logic ext_irq_in_1, // edge detected pulse
   output logic ext_irq_in_2, // edge detected pulse
   input wire logic timer8a_out_en, // timer 8a output selected
   input wire logic timer8a_out, // timer 8a output / PWM
   output logic timer8a_count_in, // synchronised count input
   input wire logic timer8b_out_en, // timer 8b output selected
   input wire logic timer8b_out, // timer 8b output / PWM
   output logic timer8b_count_in, // synchronised count input
   input wire logic timer16_out_en, // timer 16 output selected
   input wire logic timer16_out, // timer 16 output
   output logic timer16_count_in, // synchronised count input
   output logic timer16_capture_in, // synchronised capture input
   input wire logic sound_amp_en, // amplitude output selected
   input wire logic sound_amplitude_out, // amplitude signal
   input wire logic sound_out_en, // sound output selected on bit 7
   input wire logic sound_sel_freq, // 1 = frequency, 0 = composed
   input wire logic sound_composed_out, // composed sound signal
   input wire logic sound_frequency_out, // frequency sound signal
   input wire logic clk_out_en, // clock output selected
   input wire logic programmable_clock_out, // clock output signal
   input wire logic uart_tx_en, // uart transmit selected
   input wire logic uart_transmit, // uart transmit data
   output logic uart_receive, // synchronised receive data
   input wire logic csi_so_en, // serial out selected
   input wire logic csi_serial_out, // serial data out
   output logic csi_serial_in, // synchronised serial in
   input wire logic csi_master, // 1 = clock generated here
   input wire logic csi_clock_drive, // generated serial clock
   output logic csi_serial_clock, // synchronised serial clock in
   input wire logic bus_tx_data, // bus transmit data
   output logic bus_transmit, // dedicated transmit pin
   input wire logic [2:0] bus_rx_pins, // dedicated receive pins
   output logic bus_receive_0, // synchronised receive 0
   output logic bus_receive_1, // synchronised receive 1
   output logic bus_receive_2 // synchronised receive 2
);
   port_pin_function_mux_pkg::state_t st;
   port_pin_function_mux_pkg::state_t next_st;
   logic [39:0] seg_on_pin;
   logic [7:0] p12_alt_oe;
   logic [7:0] p12_alt_val;

   // edge match for one synchronised interrupt line
   function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic last);
      logic rise;
      logic fall;
      rise = now & ~last;
      fall = ~now & last;
      case (port_pin_function_mux_pkg::edge_sel_t'(sel))
         port_pin_function_mux_pkg::edge_rise: edge_hit = rise;
         port_pin_function_mux_pkg::edge_fall: edge_hit = fall;
         port_pin_function_mux_pkg::edge_both: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   // segment k sits on pin 39-k: port 12 bit 7 carries segment 0
   always_comb
   begin
      for (int i = 0; i < `SEG_COUNT; i++)
      begin
         seg_on_pin[i] = lcd_segment_lines[`SEG_COUNT - 1 - i];
      end
   end

   // port 12 alternate outputs; sck drives only as clock master
   always_comb
   begin
      p12_alt_oe = 8'h00;
      p12_alt_val = 8'h00;
      p12_alt_oe[`P12_CLKOUT_BIT] = clk_out_en;
      p12_alt_val[`P12_CLKOUT_BIT] = programmable_clock_out;
      p12_alt_oe[`P12_T16_BIT] = timer16_out_en;
      p12_alt_val[`P12_T16_BIT] = timer16_out;
      p12_alt_oe[`P12_TXD_BIT] = uart_tx_en;
      p12_alt_val[`P12_TXD_BIT] = uart_transmit;
      p12_alt_oe[`P12_SCK_BIT] = csi_master;
      p12_alt_val[`P12_SCK_BIT] = csi_clock_drive;
      p12_alt_oe[`P12_SO_BIT] = csi_so_en;
      p12_alt_val[`P12_SO_BIT] = csi_serial_out;
   end

   // pin drivers; masked by reset so every port pin floats as input
   always_comb
   begin
      p0_out = p0_latch;
      p0_oe = p0_dir_out & {5{reset_n}};
      p0_out[`P0_T8A_BIT] = timer8a_out_en ? timer8a_out : p0_latch[`P0_T8A_BIT];
      p0_oe[`P0_T8A_BIT] = reset_n & (timer8a_out_en | p0_dir_out[`P0_T8A_BIT]);
      p0_out[`P0_T8B_BIT] = timer8b_out_en ? timer8b_out : p0_latch[`P0_T8B_BIT];
      p0_oe[`P0_T8B_BIT] = reset_n & (timer8b_out_en | p0_dir_out[`P0_T8B_BIT]);
      p4_out = p4_latch;
      p4_oe = p4_dir_out & {8{reset_n}};
      p4_out[`P4_AMP_BIT] = sound_amp_en ? sound_amplitude_out : p4_latch[`P4_AMP_BIT];
      p4_oe[`P4_AMP_BIT] = reset_n & (sound_amp_en | p4_dir_out[`P4_AMP_BIT]);
      // one selector means composed and frequency can never collide
      p4_out[`P4_SND_BIT] = sound_out_en ?
         (sound_sel_freq ? sound_frequency_out : sound_composed_out) :
         p4_latch[`P4_SND_BIT];
      p4_oe[`P4_SND_BIT] = reset_n & (sound_out_en | p4_dir_out[`P4_SND_BIT]);
      for (int i = 0; i < `SEG_COUNT; i++)
      begin
         if (seg_func[i])
         begin
            segp_out[i] = seg_on_pin[i];
            segp_oe[i] = reset_n;
         end
         else if (i >= 32 && p12_alt_oe[i[2:0]])
         begin
            segp_out[i] = p12_alt_val[i[2:0]];
            segp_oe[i] = reset_n;
         end
         else
         begin
            segp_out[i] = segp_latch[i];
            segp_oe[i] = reset_n & segp_dir_out[i];
         end
      end
      analog_in_lines = p1_in;
      bus_transmit = st.bus_tx;
   end

   // read-back: driven bits show the drive value, others the synchronised pin,
   // so a pin read lags its level by two cycles
   assign p0_rd = (p0_oe & p0_out) | (~p0_oe & st.pin_sync[4:0]);
   assign p1_rd = st.pin_sync[8:5];
   assign p4_rd = (p4_oe & p4_out) | (~p4_oe & st.pin_sync[16:9]);
   assign segp_rd = (segp_oe & segp_out) | (~segp_oe & st.pin_sync[56:17]);

   // next state: two-stage synchronisers and edge detection
   always_comb
   begin
      next_st = st;
      next_st.irq_meta = p0_in[2:0];
      next_st.irq_sync = st.irq_meta;
      next_st.irq_last = st.irq_sync;
      next_st.irq_pulse[0] = edge_hit(irq_edge_0, st.irq_sync[0], st.irq_last[0]);
      next_st.irq_pulse[1] = edge_hit(irq_edge_1, st.irq_sync[1], st.irq_last[1]);
      next_st.irq_pulse[2] = edge_hit(irq_edge_2, st.irq_sync[2], st.irq_last[2]);
      // no pulse until the history is filled: a pin idling high is no rising edge
      next_st.irq_warm = {st.irq_warm[1:0], 1'b1};
      if (!st.irq_warm[2])
         next_st.irq_pulse = 3'h0;
      next_st.t_meta = {segp_in[32 + `P12_CAP_BIT], segp_in[32 + `P12_T16_BIT],
         p0_in[`P0_T8B_BIT], p0_in[`P0_T8A_BIT]};
      next_st.t_sync = st.t_meta;
      next_st.r_meta = {segp_in[32 + `P12_SI_BIT], segp_in[32 + `P12_SCK_BIT],
         segp_in[32 + `P12_RXD_BIT]};
      next_st.r_sync = st.r_meta;
      next_st.bus_tx = bus_tx_data;
      next_st.pin_meta = {segp_in, p4_in, p1_in, p0_in};
      next_st.pin_sync = st.pin_meta;
      next_st.bus_meta = bus_rx_pins;
      next_st.bus_sync = st.bus_meta;
   end

   // state register; bus transmit idles high
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.bus_tx <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign ext_irq_in_0 = st.irq_pulse[0];
   assign ext_irq_in_1 = st.irq_pulse[1];
   assign ext_irq_in_2 = st.irq_pulse[2];
   assign timer8a_count_in = st.t_sync[0];
   assign timer8b_count_in = st.t_sync[1];
   assign timer16_count_in = st.t_sync[2];
   assign timer16_capture_in = st.t_sync[3];
   assign uart_receive = st.r_sync[0];
   assign csi_serial_clock = st.r_sync[1];
   assign csi_serial_in = st.r_sync[2];

   // dedicated bus receive lines, same two-stage crossing
   assign bus_receive_0 = st.bus_sync[0];
   assign bus_receive_1 = st.bus_sync[1];
   assign bus_receive_2 = st.bus_sync[2];

   // segment override ignores the direction setting
   seg_override_a: assert property (@(posedge clk) disable iff (!reset_n)
      seg_func[0] |-> (segp_oe[0] && segp_out[0] == lcd_segment_lines[39]))
      else $error("segment pin not driven by segment");
   reverse_map_a: assert property (@(posedge clk) disable iff (!reset_n)
      seg_func[39] |-> segp_out[39] == lcd_segment_lines[0])
      else $error("segment order wrong");
   // the edge select must hold while the pulse is being formed
   sequence rise_seen_s;
      (irq_edge_0 == 2'h1 && !p0_in[0]) ##1 (irq_edge_0 == 2'h1 && p0_in[0]) [*4];
   endsequence
   irq_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
      rise_seen_s |-> ##[0:2] ext_irq_in_0)
      else $error("rising edge missed");
   irq_none_a: assert property (@(posedge clk) disable iff (!reset_n)
      (irq_edge_1 == 2'h0) [*2] |-> !ext_irq_in_1)
      else $error("irq with no edge selected");
   // a slave clock pin is released unless software made it a plain output or a segment
   sck_slave_a: assert property (@(posedge clk) disable iff (!reset_n)
      !csi_master && !seg_func[37] && !segp_dir_out[37] |-> !segp_oe[37])
      else $error("serial clock driven as slave");
   t8a_out_a: assert property (@(posedge clk) disable iff (!reset_n)
      timer8a_out_en |-> p0_oe[3] && p0_out[3] == timer8a_out)
      else $error("timer output missing");
   sound_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      sound_out_en && sound_sel_freq |-> p4_out[7] == sound_frequency_out)
      else $error("wrong sound source");
   // the first cycle after reset still shows the idle level
   bus_tx_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> bus_transmit == $past(bus_tx_data))
      else $error("bus transmit lag wrong");
   cnt_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(p0_in[3]) ##1 p0_in[3] [*3] |-> timer8a_count_in)
      else $error("count input not synchronised");
   dir_a: assert property (@(posedge clk) disable iff (!reset_n)
      !p4_dir_out[0] |-> !p4_oe[0])
      else $error("input pin driving");
endmodule
`default_nettype wire

//--- port_pin_board.sv
/*
 board-side model of the multiplexed port pins.
 assumes the bench sets the level each external source applies.
*/
`timescale 1ns/100ps
`default_nettype none
module port_pin_board (
   input wire logic [4:0] p0_out, // device drive
   input wire logic [4:0] p0_oe, // device enable
   input wire logic [7:0] p4_out, // device drive
   input wire logic [7:0] p4_oe, // device enable
   input wire logic [39:0] segp_out, // device drive
   input wire logic [39:0] segp_oe, // device enable
   input wire logic [4:0] p0_ext, // board level
   input wire logic [7:0] p4_ext, // board level
   input wire logic [39:0] segp_ext, // board level
   output logic [4:0] p0_in, // resolved pin
   output logic [7:0] p4_in, // resolved pin
   output logic [39:0] segp_in // resolved pin
);
   // board sources sit behind resistors, so an enabled pin driver wins
   assign p0_in = (p0_oe & p0_out) | (~p0_oe & p0_ext);
   assign p4_in = (p4_oe & p4_out) | (~p4_oe & p4_ext);
   assign segp_in = (segp_oe & segp_out) | (~segp_oe & segp_ext);
endmodule
`default_nettype wire

//--- tb_port_pin_function_mux.sv
/*
 self-checking bench for the port pin function multiplexer.
 assumes the board model resolves every two-way pin.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_port_pin_function_mux;
   logic clk, reset_n;
   logic [4:0] p0_in, p0_out, p0_oe, p0_latch, p0_dir_out, p0_rd, p0_ext;
   logic [3:0] p1_in, analog_in_lines, p1_rd;
   logic [7:0] p4_in, p4_out, p4_oe, p4_latch, p4_dir_out, p4_rd, p4_ext;
   logic [39:0] segp_in, segp_out, segp_oe, segp_latch, segp_dir_out, segp_rd, segp_ext;
   logic [39:0] seg_func, lcd_segment_lines, e_oe, e_out, obs;
   logic [1:0] irq_edge_0, irq_edge_1, irq_edge_2;
   logic ext_irq_in_0, ext_irq_in_1, ext_irq_in_2, timer8a_out_en, timer8a_out;
   logic timer8a_count_in, timer8b_out_en, timer8b_out, timer8b_count_in;
   logic timer16_out_en, timer16_out, timer16_count_in, timer16_capture_in;
   logic sound_amp_en, sound_amplitude_out, sound_out_en, sound_sel_freq;
   logic sound_composed_out, sound_frequency_out, clk_out_en, programmable_clock_out;
   logic uart_tx_en, uart_transmit, uart_receive, csi_so_en, csi_serial_out, csi_serial_in;
   logic csi_master, csi_clock_drive, csi_serial_clock, bus_tx_data, bus_transmit;
   logic [2:0] bus_rx_pins;
   logic bus_receive_0, bus_receive_1, bus_receive_2;
   logic [63:0] r [5];
   logic [39:0] exp_q [$];
   integer n_errors = 0, check_count = 0, seed = 1654, i, k, base, irq_cnt = 0;
   event got;

   port_pin_function_mux i_dut (.*);
   port_pin_board i_board (.*);

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // pulses are counted on every line at once
   always @(posedge clk) irq_cnt <= irq_cnt + ext_irq_in_0 + ext_irq_in_1 + ext_irq_in_2;

   task automatic chk(input logic [39:0] e, input logic [39:0] o);
      exp_q.push_back(e);
      obs = o;
      ->got;
      #0;
   endtask

   // oldest note is taken whenever a result is posted
   always @(got)
   begin
      logic [39:0] e;
      e = exp_q.pop_front();
      check_count++;
      if (e !== obs)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, obs, e);
      end
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard: the sequence needs far fewer cycles
   initial
   begin
      #100000;
      n_errors++;
      end_of_test();
   end

   initial
   begin
      reset_n = 1'b0;
      {p0_latch, p1_in, p4_latch, p0_ext, p4_ext, irq_edge_0, irq_edge_1, irq_edge_2} = '0;
      {segp_latch, lcd_segment_lines, segp_ext, bus_rx_pins, bus_tx_data} = '0;
      {seg_func, segp_dir_out, p0_dir_out, p4_dir_out} = '1;
      {timer8a_out_en, timer8b_out_en, sound_amp_en, sound_out_en, clk_out_en} = 5'h1f;
      {uart_tx_en, csi_so_en, csi_master, timer16_out_en} = 4'hf;
      {timer8a_out, timer8b_out, sound_amplitude_out, sound_composed_out} = '0;
      {sound_frequency_out, programmable_clock_out, uart_transmit, csi_serial_out} = '0;
      {csi_clock_drive, timer16_out, sound_sel_freq} = '0;
      // everything requested as output while reset is still low
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(40'h0, 40'({p0_oe, p4_oe}));
      chk(40'h0, segp_oe);
      chk(40'h1, 40'(bus_transmit));
      @(posedge clk);
      reset_n <= 1'b1;
      $display("reset test done");
      // random direction, latch, segment select and board levels
      {timer8a_out_en, timer8b_out_en, sound_amp_en, sound_out_en, clk_out_en} <= '0;
      {uart_tx_en, csi_so_en, csi_master, timer16_out_en} <= '0;
      for (k = 0; k < 12; k++)
      begin
         for (i = 0; i < 5; i++)
            r[i] = {$random(seed), $random(seed)};
         @(posedge clk);
         {segp_dir_out, p0_dir_out, p4_dir_out} <= r[0][52:0];
         {segp_latch, p0_latch, p4_latch} <= r[1][52:0];
         {segp_ext, p0_ext, p4_ext} <= r[2][52:0];
         {seg_func, p1_in} <= r[3][43:0];
         lcd_segment_lines <= r[4][39:0];
         // pin read-back passes two flip-flops
         repeat (2) @(posedge clk);
         @(negedge clk);
         for (i = 0; i < 40; i++)
         begin
            e_oe[i] = seg_func[i] | segp_dir_out[i];
            e_out[i] = seg_func[i] ? lcd_segment_lines[39 - i] : segp_latch[i];
         end
         chk(e_oe, segp_oe);
         chk(e_out & e_oe, segp_out & segp_oe);
         chk((e_oe & e_out) | (~e_oe & segp_ext), segp_rd);
         chk(40'({p0_dir_out, p4_dir_out, p0_latch & p0_dir_out, p4_latch & p4_dir_out}),
            40'({p0_oe, p4_oe, p0_out & p0_oe, p4_out & p4_oe}));
         chk(40'({(p0_dir_out & p0_latch) | (~p0_dir_out & p0_ext), p4_ext & ~p4_dir_out}),
            40'({p0_rd, p4_rd & ~p4_dir_out}));
         chk(40'({p1_in, p1_in}), 40'({analog_in_lines, p1_rd}));
      end
      $display("direction test done");
      // alternate outputs with both sound sources
      for (k = 0; k < 4; k++)
      begin
         r[0] = {$random(seed), $random(seed)};
         @(posedge clk);
         {seg_func, segp_dir_out, p0_dir_out, p4_dir_out} <= '0;
         {timer8a_out_en, timer8b_out_en, sound_amp_en, sound_out_en, clk_out_en} <= 5'h1f;
         {uart_tx_en, csi_so_en, csi_master, timer16_out_en} <= 4'hf;
         {timer8a_out, timer8b_out, sound_amplitude_out, sound_composed_out} <= r[0][3:0];
         {sound_frequency_out, programmable_clock_out, uart_transmit} <= r[0][6:4];
         {csi_serial_out, csi_clock_drive, timer16_out} <= r[0][9:7];
         sound_sel_freq <= k[0];
         @(negedge clk);
         chk(40'h1ff, 40'({p0_oe[4:3], p4_oe[7:6], segp_oe[38:36], segp_oe[33:32]}));
         chk(40'({timer8b_out, timer8a_out, sound_sel_freq ? sound_frequency_out :
            sound_composed_out, sound_amplitude_out, csi_serial_out, csi_clock_drive,
            uart_transmit, timer16_out, programmable_clock_out}),
            40'({p0_out[4:3], p4_out[7:6], segp_out[38:36], segp_out[33:32]}));
      end
      // segment beats the clock output; slave serial clock is released
      @(posedge clk);
      seg_func <= 40'h0100000000;
      csi_master <= 1'b0;
      @(negedge clk);
      chk(40'({lcd_segment_lines[7], 1'b0}), 40'({segp_out[32], segp_oe[37]}));
      $display("alternate test done");
      // synchronised inputs and the registered bus transmit pin
      @(posedge clk);
      {timer8a_out_en, timer8b_out_en, sound_amp_en, sound_out_en, clk_out_en} <= '0;
      {uart_tx_en, csi_so_en, timer16_out_en, seg_func} <= '0;
      for (k = 0; k < 6; k++)
      begin
         r[0] = {$random(seed), $random(seed)};
         @(posedge clk);
         segp_ext <= r[0][39:0];
         {p0_ext, bus_rx_pins, bus_tx_data} <= r[0][48:40];
         // one edge for the transmit register, two for the synchronisers
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk(40'(bus_tx_data), 40'(bus_transmit));
         chk(40'({segp_ext[35], segp_ext[34:33], segp_ext[37], segp_ext[39], p0_ext[3],
            p0_ext[4], bus_rx_pins}), 40'({uart_receive, timer16_capture_in,
            timer16_count_in, csi_serial_clock, csi_serial_in, timer8a_count_in,
            timer8b_count_in, bus_receive_2, bus_receive_1, bus_receive_0}));
      end
      $display("input sync test done");
      // every edge mode: one pulse per qualifying edge, three cycles late
      for (k = 0; k < 4; k++)
      begin
         @(posedge clk);
         {irq_edge_0, irq_edge_1, irq_edge_2} <= {3{k[1:0]}};
         p0_ext[2:0] <= 3'h0;
         repeat (4) @(posedge clk);
         base = irq_cnt;
         p0_ext[2:0] <= 3'h7;
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk(40'(k[0] ? 3'h7 : 3'h0), 40'({ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}));
         @(posedge clk);
         @(negedge clk);
         chk(40'h0, 40'({ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}));
         @(posedge clk);
         p0_ext[2:0] <= 3'h0;
         repeat (5) @(posedge clk);
         @(negedge clk);
         chk(40'(3 * (k[0] + k[1])), 40'(irq_cnt - base));
      end
      $display("edge test done");
      end_of_test();
   end
endmodule
`default_nettype wire
